// *** common/dcsr_map.vh ***
`ifndef DCSR_MAP_VH
`define DCSR_MAP_VH
// Register byte offsets (32-bit aligned words on the register bus)
`define DCSR_OFF_COUNT_LOW      12'h000
`define DCSR_OFF_COUNT_HIGH     12'h004
`define DCSR_OFF_LIMIT_LOW      12'h008
`define DCSR_OFF_LIMIT_HIGH     12'h00C
`define DCSR_OFF_INTV_LOW       12'h010
`define DCSR_OFF_INTV_HIGH      12'h014
`define DCSR_OFF_HOLD           12'h018
// Widths and fields
`define DCSR_ADDR_W             12
`define DCSR_HALF_W             16
`define DCSR_WORD_LSB           2
`define DCSR_UPPER_HI           31
`define DCSR_UPPER_LO           16
// Reset values
`define DCSR_HALF_ZERO          16'h0000
`define DCSR_ADDR_ZERO          12'h000
`define DCSR_WORD_ZERO          32'h0000_0000
// Bus responses
`define DCSR_RESP_OKAY          2'h0
`define DCSR_RESP_SLVERR        2'h2
`endif

// *** rtl/dcsr_cfg_mirror.v ***
`timescale 1ns/1ps
`default_nettype none
`include "dcsr_map.vh"
// Mirror of the four configuration halfwords, reloaded on every reset
module dcsr_cfg_mirror (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        rst_in,
  // Configuration words from the nonvolatile store
  input  wire [15:0] cfg_limit_low_in,
  input  wire [15:0] cfg_limit_high_in,
  input  wire [15:0] cfg_intv_low_in,
  input  wire [15:0] cfg_intv_high_in,
  // Mirrored values
  output reg  [15:0] limit_low_out,
  output reg  [15:0] limit_high_out,
  output reg  [15:0] intv_low_out,
  output reg  [15:0] intv_high_out
);

  // Load pulse: first clock after reset release
  reg load_pend_q;

  // Async reset may only load constants, so the value is caught by a clock
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      load_pend_q <= 1'b1;
    end else begin
      load_pend_q <= 1'b0;
    end
  end

  // Mirrors copy every configuration bit at reset; no bus path writes them
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      limit_low_out  <= `DCSR_HALF_ZERO;
      limit_high_out <= `DCSR_HALF_ZERO;
      intv_low_out   <= `DCSR_HALF_ZERO;
      intv_high_out  <= `DCSR_HALF_ZERO;
    end else if (load_pend_q) begin
      limit_low_out  <= cfg_limit_low_in;
      limit_high_out <= cfg_limit_high_in;
      intv_low_out   <= cfg_intv_low_in;
      intv_high_out  <= cfg_intv_high_in;
    end
  end

endmodule // dcsr_cfg_mirror
`default_nettype wire

// *** rtl/dcsr_top.v ***
// Summary of operation
// - counter bits 31:16 read-only, follow the live counter
// - limit low register returns nv low word
// - limit high register returns nv high word
// - interval low register returns nv low word
// - mirrors load configuration bits at reset
// - counter bits 15:0 read-only register
// - interval high register returns nv high word
// - hold resets zero, loads on counter read
`timescale 1ns/1ps
`default_nettype none
`include "dcsr_map.vh"
// Register map: one aligned 32-bit word per register, data in bits 15:0
//   0x000  deadman_count_low            live counter bits 15:0
//   0x004  deadman_count_high           live counter bits 31:16
//   0x008  count_limit_status_low       mirror of the low limit word
//   0x00C  count_limit_status_high      mirror of the high limit word
//   0x010  window_interval_status_low   mirror of the low interval word
//   0x014  window_interval_status_high  mirror of the high interval word
//   0x018  count_high_hold              upper count half at the last count read
// Bits 31:16 of every word read as zero.
// Any other address answers SLVERR on either channel and reads zero.
// Every register is read-only: a write is answered but never stored.
// Reads have no side effect except the reload of the hold.

module dcsr_top (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        rst_in,
  // Live deadman counter from the timer core
  input  wire [31:0] deadman_count_in,
  // Nonvolatile configuration words
  input  wire [15:0] nv_count_limit_low_word_in,
  input  wire [15:0] nv_count_limit_high_word_in,
  input  wire [15:0] nv_window_interval_low_word_in,
  input  wire [15:0] nv_window_interval_high_word_in,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid_in,
  output wire        s_axi_awready_out,
  input  wire [11:0] s_axi_awaddr_in,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid_in,
  output wire        s_axi_wready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  // AXI4-Lite write response
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  output reg  [1:0]  s_axi_bresp_out,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid_in,
  output wire        s_axi_arready_out,
  input  wire [11:0] s_axi_araddr_in,
  // AXI4-Lite read data
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out
);

  // Mirrored configuration halves
  // Driven only by the mirror module; no bus path reaches them
  wire [15:0] limit_low_w;
  wire [15:0] limit_high_w;
  wire [15:0] intv_low_w;
  wire [15:0] intv_high_w;

  // Write channel capture
  // Both flags clear together on the edge that raises the response
  reg         aw_held_q;   // Write address taken, awaiting data or response
  reg         w_held_q;    // Write data taken
  reg  [11:0] awaddr_q;    // Captured write address
  // Hold of upper counter half, loaded on any counter read
  reg  [15:0] count_high_hold_q;
  // Read decode
  reg  [31:0] rdata_d;
  reg  [1:0]  rresp_d;

  // Word-aligned address check
  // Only the seven exact offsets count as mapped; an offset inside a word
  // is refused rather than rounded down, so a misaligned access is
  // reported instead of silently aliasing onto a register.
  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = (addr == `DCSR_OFF_COUNT_LOW)  || (addr == `DCSR_OFF_COUNT_HIGH) ||
                  (addr == `DCSR_OFF_LIMIT_LOW)  || (addr == `DCSR_OFF_LIMIT_HIGH) ||
                  (addr == `DCSR_OFF_INTV_LOW)   || (addr == `DCSR_OFF_INTV_HIGH)  ||
                  (addr == `DCSR_OFF_HOLD);
    end
  endfunction

  // Configuration mirror loaded once per reset
  // The mirrors read zero in reset and at the first edge after release,
  // so a master must let one edge pass before reading them.
  dcsr_cfg_mirror u_mirror (
    .mclk_in           (mclk_in),
    .rst_in            (rst_in),
    .cfg_limit_low_in  (nv_count_limit_low_word_in),
    .cfg_limit_high_in (nv_count_limit_high_word_in),
    .cfg_intv_low_in   (nv_window_interval_low_word_in),
    .cfg_intv_high_in  (nv_window_interval_high_word_in),
    .limit_low_out     (limit_low_w),
    .limit_high_out    (limit_high_w),
    .intv_low_out      (intv_low_w),
    .intv_high_out     (intv_high_w)
  );

  // Ready while that channel has not yet been taken and no response pends
  // Readies depend only on local flops, so there is no combinational
  // path from the master's valid back to its own ready.
  assign s_axi_awready_out = !aw_held_q && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_held_q && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;

  // Write path: address and data in either order, then one response
  // A channel taken early is held until its partner arrives, and neither
  // ready returns until the response is accepted: at most one write is in
  // flight, so no queue is needed.
  // Write data and strobes are never stored, since nothing here is writable.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      // Idle: both channels ready, no response pending
      aw_held_q        <= 1'b0;
      w_held_q         <= 1'b0;
      awaddr_q         <= `DCSR_ADDR_ZERO;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `DCSR_RESP_OKAY;
    end else begin
      // Address taken: keep it until the data has arrived too
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_in;
      end
      // Data taken: only its arrival matters, the value is dropped
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_q <= 1'b1;
      end
      // Both halves present: raise the response and free both channels
      if (aw_held_q && w_held_q && !s_axi_bvalid_out) begin
        // Every register is read-only: data is dropped, nothing changes
        s_axi_bvalid_out <= 1'b1;
        aw_held_q        <= 1'b0;
        w_held_q         <= 1'b0;
        // Mapped read-only addresses answer OKAY so software sees no fault
        s_axi_bresp_out  <= is_mapped(awaddr_q) ? `DCSR_RESP_OKAY : `DCSR_RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Read decode of the register map
  // Decoded straight from the request address so the answer can be
  // registered on the edge that takes the request; the defaults give zero
  // data and SLVERR for any unmapped or misaligned address.
  always @* begin
    rdata_d = `DCSR_WORD_ZERO;
    rresp_d = `DCSR_RESP_OKAY;
    // Unmapped reads fall to the default branch below
    case (s_axi_araddr_in)
      `DCSR_OFF_COUNT_LOW: begin
        rdata_d = {`DCSR_HALF_ZERO, deadman_count_in[`DCSR_HALF_W-1:0]};
      end
      `DCSR_OFF_COUNT_HIGH: begin
        rdata_d = {`DCSR_HALF_ZERO, deadman_count_in[`DCSR_UPPER_HI:`DCSR_UPPER_LO]};
      end
      `DCSR_OFF_LIMIT_LOW: begin
        rdata_d = {`DCSR_HALF_ZERO, limit_low_w};
      end
      `DCSR_OFF_LIMIT_HIGH: begin
        rdata_d = {`DCSR_HALF_ZERO, limit_high_w};
      end
      `DCSR_OFF_INTV_LOW: begin
        rdata_d = {`DCSR_HALF_ZERO, intv_low_w};
      end
      `DCSR_OFF_INTV_HIGH: begin
        rdata_d = {`DCSR_HALF_ZERO, intv_high_w};
      end
      `DCSR_OFF_HOLD: begin
        rdata_d = {`DCSR_HALF_ZERO, count_high_hold_q};
      end
      default: begin
        rresp_d = `DCSR_RESP_SLVERR;
      end
    endcase
  end

  // Read path: one-cycle answer, data registered
  // Data and response stand unchanged until the master takes them, since
  // arready stays low while rvalid is high and nothing else loads them.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      // No answer pending after reset
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= `DCSR_WORD_ZERO;
      s_axi_rresp_out  <= `DCSR_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      // Request taken: register the answer, arready drops with it
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= rdata_d;
      s_axi_rresp_out  <= rresp_d;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      // Master took the answer: free the channel for the next read
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // Hold captures upper half on a read of either counter half
  // Reading low then hold gives a coherent 32-bit snapshot
  // Limitation: a read of the hold alone does not refresh it, so it shows
  // zero or a stale half if no counter read came before it.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      // Hold starts empty on every reset
      count_high_hold_q <= `DCSR_HALF_ZERO;
    end else if (s_axi_arvalid_in && s_axi_arready_out &&
                 ((s_axi_araddr_in == `DCSR_OFF_COUNT_LOW) ||
                  (s_axi_araddr_in == `DCSR_OFF_COUNT_HIGH))) begin
      count_high_hold_q <= deadman_count_in[`DCSR_UPPER_HI:`DCSR_UPPER_LO];
    end
  end

endmodule // dcsr_top
`default_nettype wire

// *** sim/dcsr_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// Read-side protocol and mirror checks on the register bus
module dcsr_props (
  // Clock, reset and read channels
  input wire logic        mclk_in, rst_in, s_axi_arvalid_in, s_axi_arready_out,
  input wire logic        s_axi_rvalid_out, s_axi_rready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  // Configuration words
  input wire logic [15:0] nv_count_limit_low_word_in, nv_window_interval_low_word_in
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire logic ar_tk; // Read address taken this edge
  assign ar_tk = s_axi_arvalid_in && s_axi_arready_out;
  rd_answer_a: assert property (ar_tk |=> s_axi_rvalid_out) else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  rd_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("second read accepted");
  // Mirrors must follow the configuration words, not a constant
  lim_low_a: assert property (ar_tk && s_axi_araddr_in == 12'h008 |=> s_axi_rdata_out == {16'h0000, nv_count_limit_low_word_in})
    else $error("limit low mismatch");
  intv_low_a: assert property (ar_tk && s_axi_araddr_in == 12'h010 |=> s_axi_rdata_out == {16'h0000, nv_window_interval_low_word_in})
    else $error("interval low mismatch");
  lim_okay_a: assert property (ar_tk && s_axi_araddr_in == 12'h008 |=> s_axi_rresp_out == 2'h0) else $error("bad read resp");
  bad_addr_a: assert property (ar_tk && s_axi_araddr_in == 12'h01C |=> s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0)
    else $error("unmapped read answered");
  rst_idle_a: assert property ($fell(rst_in) |-> !s_axi_rvalid_out) else $error("read valid after reset");
  cover property (ar_tk && s_axi_araddr_in == 12'h018);
  cover property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2);
  cover property (s_axi_rvalid_out && !s_axi_rready_in);
endmodule // dcsr_props
bind dcsr_top dcsr_props chk_u (.mclk_in, .rst_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .s_axi_araddr_in, .s_axi_rdata_out, .s_axi_rresp_out, .nv_count_limit_low_word_in,
  .nv_window_interval_low_word_in);
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dcsr_map.vh"
module tb_top;
  logic        mclk_in = 0, rst_in = 1;
  logic [31:0] deadman_count_in = 32'h0, s_axi_wdata_in = 32'h0;
  logic [15:0] nv_count_limit_low_word_in = 16'h1357, nv_count_limit_high_word_in = 16'h2468;
  logic [15:0] nv_window_interval_low_word_in = 16'h9ABC, nv_window_interval_high_word_in = 16'hDEF0;
  logic        s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
  logic [11:0] s_axi_awaddr_in = 12'h0, s_axi_araddr_in = 12'h0;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  wire logic   s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  wire logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  wire logic [31:0] s_axi_rdata_out;
  int error_cnt = 0, comparisons = 0;
  dcsr_top dut_u (.mclk_in, .rst_in, .deadman_count_in, .nv_count_limit_low_word_in, .nv_count_limit_high_word_in,
    .nv_window_interval_low_word_in, .nv_window_interval_high_word_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_awaddr_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_bvalid_out,
    .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in, .s_axi_rvalid_out,
    .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out);
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp2(input logic [1:0] g, input logic [1:0] e);
    cmp32({30'h0, g}, {30'h0, e});
  endtask
  // Read one register, holding each request until its ready edge
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    do begin @(negedge mclk_in); t = s_axi_arready_out; @(posedge mclk_in); end while (!t);
    s_axi_arvalid_in <= 0;
    s_axi_rready_in <= 1;
    do begin @(negedge mclk_in); t = s_axi_rvalid_out; d = s_axi_rdata_out; r = s_axi_rresp_out; @(posedge mclk_in); end while (!t);
    s_axi_rready_in <= 0;
    cmp32(d, e);
    cmp2(r, er);
  endtask
  // Write one register; address and data channels are released on their own edges
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, ok_a, ok_w, t;
    logic [1:0] r;
    ta = 0;
    tw = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    do begin
      @(negedge mclk_in);
      ok_a = s_axi_awready_out && !ta;
      ok_w = s_axi_wready_out && !tw;
      @(posedge mclk_in);
      if (ok_a) begin s_axi_awvalid_in <= 0; ta = 1; end
      if (ok_w) begin s_axi_wvalid_in <= 0; tw = 1; end
    end while (!(ta && tw));
    s_axi_bready_in <= 1;
    do begin @(negedge mclk_in); t = s_axi_bvalid_out; r = s_axi_bresp_out; @(posedge mclk_in); end while (!t);
    s_axi_bready_in <= 0;
    cmp2(r, er);
  endtask
  // Reset held 20 cycles; mirrors readable from the second edge after release
  task automatic do_reset;
    rst_in <= 1;
    repeat (20) @(posedge mclk_in);
    rst_in <= 0;
    repeat (2) @(posedge mclk_in);
  endtask
  task automatic t_mirrors;
    rchk(`DCSR_OFF_HOLD, 32'h0, 2'h0);
    rchk(`DCSR_OFF_COUNT_HIGH, 32'h0, 2'h0);
    rchk(`DCSR_OFF_LIMIT_LOW, 32'h1357, 2'h0);
    rchk(`DCSR_OFF_LIMIT_HIGH, 32'h2468, 2'h0);
    rchk(`DCSR_OFF_INTV_LOW, 32'h9ABC, 2'h0);
    rchk(`DCSR_OFF_INTV_HIGH, 32'hDEF0, 2'h0);
  endtask
  // The hold keeps the upper half seen at the last counter read
  task automatic t_count;
    deadman_count_in <= 32'hA5C3_1234;
    rchk(`DCSR_OFF_COUNT_LOW, 32'h1234, 2'h0);
    deadman_count_in <= 32'h0F0F_5555;
    rchk(`DCSR_OFF_HOLD, 32'hA5C3, 2'h0);
    rchk(`DCSR_OFF_COUNT_HIGH, 32'h0F0F, 2'h0);
    rchk(`DCSR_OFF_HOLD, 32'h0F0F, 2'h0);
  endtask
  // Writes change nothing; unmapped places answer with an error
  task automatic t_write;
    wr(`DCSR_OFF_COUNT_HIGH, 32'hFFFF_FFFF, 2'h0);
    wr(`DCSR_OFF_LIMIT_LOW, 32'h0000_FFFF, 2'h0);
    rchk(`DCSR_OFF_LIMIT_LOW, 32'h1357, 2'h0);
    rchk(`DCSR_OFF_COUNT_HIGH, 32'h0F0F, 2'h0);
    wr(12'h01C, 32'h0, 2'h2);
    rchk(12'h01C, 32'h0, 2'h2);
  endtask
  // A second reset reloads the mirrors from new configuration words
  task automatic t_reload;
    nv_count_limit_low_word_in <= 16'h8001;
    nv_window_interval_high_word_in <= 16'h7FFE;
    do_reset();
    rchk(`DCSR_OFF_LIMIT_LOW, 32'h8001, 2'h0);
    rchk(`DCSR_OFF_INTV_HIGH, 32'h7FFE, 2'h0);
    rchk(`DCSR_OFF_HOLD, 32'h0, 2'h0);
  endtask
  task automatic stop_test;
    $display("TB: errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end
  initial begin
    do_reset();
    t_mirrors();
    t_count();
    t_write();
    t_reload();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
